// ==== pkg/eac_pkg.sv ====
// Constants for the EEPROM access control block.
// Assumes a byte-wide register port from the processor core.
package eac_pkg;

  // ****************************************************************
  // Register addresses and field positions
  // ****************************************************************
  localparam logic [1:0] ADDR_CONTROL   = 2'h0;
  localparam logic [1:0] ADDR_DATA      = 2'h1;
  localparam logic [1:0] ADDR_ADDR_LOW  = 2'h2;
  localparam logic [1:0] ADDR_ADDR_HIGH = 2'h3;

  localparam int BIT_READ_STROBE  = 0;
  localparam int BIT_WRITE_STROBE = 1;
  localparam int BIT_ARM          = 2;
  localparam int BIT_READY_IE     = 3;
  localparam int BIT_MODE_LO      = 4;
  localparam int BIT_MODE_HI      = 5;

  localparam logic [1:0] MODE_RESET   = 2'h0;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam int         ADDR_WIDTH   = 11;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ARM_WINDOW_CYCLES  = 4;
  localparam int WRITE_STALL_CYCLES = 2;
  localparam int READ_STALL_CYCLES  = 4;
  localparam int WRITE_OSC_CYCLES   = 26368;

  // ****************************************************************
  // Modes
  // ****************************************************************
  typedef enum logic [1:0] {
    EAC_ERASE_WRITE = 2'h0,
    EAC_ERASE_ONLY  = 2'h1,
    EAC_WRITE_ONLY  = 2'h2,
    EAC_MODE_RSVD   = 2'h3
  } eac_mode_t;

endpackage

// ==== hw/eac_top.sv ====
// EEPROM access control: control, address and data registers, write
// timing, read strobe and CPU stall.
// Assumes core-side inputs on CORE_CLK; OSC_TICK is a one-cycle enable
// from the calibrated oscillator divider on the same clock.
`timescale 1ns/1ps
module eac_top
  import eac_pkg::*;
#(
  parameter int WRITE_TICKS = WRITE_OSC_CYCLES
)(
  input  wire logic                        CORE_CLK,
  input  wire logic                        NRST,
  input  wire logic                        REG_WE,
  input  wire logic                        REG_RE,
  input  wire logic [1:0]                  REG_ADDR,
  input  wire logic [7:0]                  REG_WDATA,
  input  wire logic                        GLOBAL_IE,
  input  wire logic                        FLASH_SELFPROG_ENABLE,
  input  wire logic                        OSC_TICK,
  input  wire logic [7:0]                  NV_RDATA,
  output logic      [7:0]                  REG_RDATA,
  output logic                             CPU_STALL,
  output logic                             READY_IRQ,
  output logic                             NV_WRITE_START,
  output logic      [1:0]                  NV_MODE,
  output logic      [eac_pkg::ADDR_WIDTH-1:0] NV_ADDRESS,
  output logic      [7:0]                  NV_WDATA
);
  import eac_pkg::*;

  logic [1:0]            prog_mode_field;
  logic                  ready_irq_enable;
  logic                  master_write_arm;
  logic                  write_strobe_alias;
  logic                  read_strobe;
  logic [ADDR_WIDTH-1:0] nv_address;
  logic [7:0]            nv_data;
  logic [2:0]            arm_count;
  logic [2:0]            stall_count;
  logic [15:0]           write_ticks;
  logic                  ctl_we;
  logic                  start_write;
  logic                  do_read;

  // ****************************************************************
  // Register write decode
  // ****************************************************************
  assign ctl_we      = REG_WE && REG_ADDR == ADDR_CONTROL;
  assign start_write = ctl_we && REG_WDATA[BIT_WRITE_STROBE] && master_write_arm
                       && !write_strobe_alias && !FLASH_SELFPROG_ENABLE;
  assign do_read     = ctl_we && REG_WDATA[BIT_READ_STROBE] && !write_strobe_alias;

  // Mode survives reset while the cell is still being programmed
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST && !write_strobe_alias)
      prog_mode_field <= MODE_RESET;
    else if (NRST && ctl_we && !write_strobe_alias)
      prog_mode_field <= REG_WDATA[BIT_MODE_HI:BIT_MODE_LO];
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      ready_irq_enable <= 1'b0;
    else if (ctl_we)
      ready_irq_enable <= REG_WDATA[BIT_READY_IE];
  end

  // ****************************************************************
  // Arm window
  // ****************************************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
    begin
      master_write_arm <= 1'b0;
      arm_count        <= 3'h0;
    end
    else if (ctl_we && REG_WDATA[BIT_ARM] && !REG_WDATA[BIT_WRITE_STROBE])
    begin
      master_write_arm <= 1'b1;
      arm_count        <= 3'(ARM_WINDOW_CYCLES);
    end
    else if (start_write)
      master_write_arm <= 1'b0;
    else if (arm_count != 3'h0)
    begin
      arm_count <= arm_count - 3'h1;
      if (arm_count == 3'h1)
        master_write_arm <= 1'b0;
    end
  end

  // ****************************************************************
  // Write timing; a write in progress is finished even across reset
  // ****************************************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (start_write && NRST)
    begin
      write_strobe_alias <= 1'b1;
      write_ticks        <= 16'(WRITE_TICKS);
    end
    else if (write_strobe_alias)
    begin
      if (OSC_TICK)
      begin
        write_ticks <= write_ticks - 16'h1;
        if (write_ticks == 16'h1)
          write_strobe_alias <= 1'b0;
      end
    end
    else if (!NRST)
    begin
      write_strobe_alias <= 1'b0;
      write_ticks        <= 16'h0;
    end
  end

  // Read strobe is seen only for one cycle; busy reads vanish
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      read_strobe <= 1'b0;
    else
      read_strobe <= do_read;
  end

  // ****************************************************************
  // Address and data
  // ****************************************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (REG_WE && !write_strobe_alias && REG_ADDR == ADDR_ADDR_LOW)
      nv_address[7:0] <= REG_WDATA;
    else if (REG_WE && !write_strobe_alias && REG_ADDR == ADDR_ADDR_HIGH)
      nv_address[ADDR_WIDTH-1:8] <= REG_WDATA[ADDR_WIDTH-9:0];
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      nv_data <= DATA_RESET;
    else if (do_read)
      nv_data <= NV_RDATA;
    else if (REG_WE && REG_ADDR == ADDR_DATA)
      nv_data <= REG_WDATA;
  end

  // ****************************************************************
  // CPU stall
  // ****************************************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      stall_count <= 3'h0;
    else if (do_read)
      stall_count <= 3'(READ_STALL_CYCLES - 1);
    else if (start_write)
      stall_count <= 3'(WRITE_STALL_CYCLES - 1);
    else if (stall_count != 3'h0)
      stall_count <= stall_count - 3'h1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      CPU_STALL <= 1'b0;
    else
      CPU_STALL <= do_read || start_write || stall_count != 3'h0;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      READY_IRQ <= 1'b0;
    else
      READY_IRQ <= ready_irq_enable && GLOBAL_IE && !write_strobe_alias
                   && !start_write && !FLASH_SELFPROG_ENABLE;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      NV_WRITE_START <= 1'b0;
    else
      NV_WRITE_START <= start_write;
  end

  always_ff @(posedge CORE_CLK)
  begin
    NV_MODE    <= prog_mode_field;
    NV_ADDRESS <= nv_address;
    NV_WDATA   <= nv_data;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      REG_RDATA <= 8'h00;
    else if (REG_RE)
      unique case (REG_ADDR)
        ADDR_CONTROL:   REG_RDATA <= {2'b00, prog_mode_field, ready_irq_enable,
                                      master_write_arm, write_strobe_alias,
                                      read_strobe};
        ADDR_DATA:      REG_RDATA <= nv_data;
        ADDR_ADDR_LOW:  REG_RDATA <= nv_address[7:0];
        ADDR_ADDR_HIGH: REG_RDATA <= {5'h00, nv_address[ADDR_WIDTH-1:8]};
      endcase
  end

endmodule

// ==== tb/eac_checker.sv ====
// Assertions on the ports of the EEPROM access control top.
// Assumes one clock, CORE_CLK, and the synchronous active-low NRST.
`timescale 1ns/1ps
module eac_checker (
  input wire logic                           CORE_CLK,
  input wire logic                           NRST,
  input wire logic                           REG_WE,
  input wire logic                           REG_RE,
  input wire logic [1:0]                     REG_ADDR,
  input wire logic [7:0]                     REG_WDATA,
  input wire logic                           GLOBAL_IE,
  input wire logic                           FLASH_SELFPROG_ENABLE,
  input wire logic [7:0]                     REG_RDATA,
  input wire logic                           CPU_STALL,
  input wire logic                           READY_IRQ,
  input wire logic                           NV_WRITE_START,
  input wire logic [1:0]                     NV_MODE,
  input wire logic [eac_pkg::ADDR_WIDTH-1:0] NV_ADDRESS,
  input wire logic [7:0]                     NV_WDATA
);
  import eac_pkg::*;
  logic [2:0] arm_left;
  logic       strobe_req;
  // Arm window mirrored from the port side, so a start outside it is caught
  always_ff @(posedge CORE_CLK)
  begin
    if (!NRST)
      arm_left <= 3'h0;
    else if (REG_WE && REG_ADDR == ADDR_CONTROL && REG_WDATA[BIT_ARM]
             && !REG_WDATA[BIT_WRITE_STROBE])
      arm_left <= 3'(ARM_WINDOW_CYCLES);
    else if (arm_left != 3'h0)
      arm_left <= arm_left - 3'h1;
  end
  assign strobe_req = REG_WE && REG_ADDR == 2'h0 && REG_WDATA[1] && arm_left != 3'h0
                      && !FLASH_SELFPROG_ENABLE;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  sequence s_wr_stall;
    CPU_STALL ##1 CPU_STALL ##1 !CPU_STALL;
  endsequence
  sequence s_rd_stall;
    CPU_STALL [*4] ##1 !CPU_STALL;
  endsequence
  a_rsvd_zero: assert property (REG_RE && REG_ADDR == 2'h0 |=> REG_RDATA[7:6] == 2'h0)
    else $error("reserved control bits read nonzero");
  a_irq_global: assert property (READY_IRQ |-> $past(GLOBAL_IE))
    else $error("ready interrupt without global enable");
  a_irq_flash: assert property (READY_IRQ |-> !$past(FLASH_SELFPROG_ENABLE))
    else $error("ready interrupt during flash programming");
  a_start_armed: assert property (NV_WRITE_START |-> $past(strobe_req))
    else $error("write start without strobe request");
  a_wr_stall: assert property (NV_WRITE_START |-> s_wr_stall)
    else $error("write stall not two cycles");
  a_rd_stall: assert property ($rose(CPU_STALL) && !NV_WRITE_START |-> s_rd_stall)
    else $error("read stall not four cycles");
  a_irq_busy: assert property (NV_WRITE_START |=> !READY_IRQ [*3])
    else $error("ready interrupt during write");
  a_busy_hold: assert property (NV_WRITE_START |=> ($stable(NV_ADDRESS) && $stable(NV_MODE)) [*4])
    else $error("address or mode changed while busy");
  a_data_copy: assert property (REG_WE && REG_ADDR == 2'h1 |=> ##1 NV_WDATA == $past(REG_WDATA, 2))
    else $error("data register not passed on");
endmodule
bind eac_top eac_checker chk_u (.CORE_CLK, .NRST, .REG_WE, .REG_RE, .REG_ADDR, .REG_WDATA,
  .GLOBAL_IE, .FLASH_SELFPROG_ENABLE, .REG_RDATA, .CPU_STALL, .READY_IRQ, .NV_WRITE_START,
  .NV_MODE, .NV_ADDRESS, .NV_WDATA);

// ==== tb/eac_core_model.sv ====
// Processor core model issuing register writes and reads.
// Assumes the block samples on the rising edge; drives on the falling one.
`timescale 1ns/1ps
module eac_core_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  input  wire logic       stall,
  output logic            we,
  output logic            re,
  output logic      [1:0] addr,
  output logic      [7:0] wdata
);
  initial
  begin
    we = 1'b0;
    re = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk);
    while (stall) @(negedge clk);
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    we = 1'b0;
    wdata = ~d; // Released bus must not look valid
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(negedge clk);
    while (stall) @(negedge clk);
    re = 1'b1;
    addr = a;
    @(negedge clk);
    re = 1'b0;
    d = rdata;
  endtask
  task automatic nv_write(input logic [7:0] c);
    wr(2'h0, c | 8'h04);
    wr(2'h0, c | 8'h02);
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the EEPROM access control top.
// Assumes the core model drives the register port, the bench the rest.
`timescale 1ns/1ps
module tb;
  import eac_pkg::*;
  typedef struct {logic [1:0] a; logic [7:0] d; logic [7:0] e;} eac_row_t;
  eac_row_t rows[7] = '{'{2'h0, 8'h10, 8'h10}, '{2'h0, 8'h20, 8'h20}, '{2'h0, 8'h30, 8'h30},
    '{2'h0, 8'hC8, 8'h08}, '{2'h1, 8'hA5, 8'hA5}, '{2'h3, 8'hFF, 8'h07}, '{2'h2, 8'h3C, 8'h3C}};
  logic clk, nrst, gie, fsp, tick, tick_en, we, re, stall, irq, start;
  logic [1:0] addr, mode;
  logic [7:0] wdata, rdata, nv_rd, nvw, v;
  logic [10:0] nva;
  int miscompares, compares, cycles, starts;
  eac_top #(.WRITE_TICKS(8)) dut_u (.CORE_CLK(clk), .NRST(nrst), .REG_WE(we), .REG_RE(re),
    .REG_ADDR(addr), .REG_WDATA(wdata), .GLOBAL_IE(gie), .FLASH_SELFPROG_ENABLE(fsp),
    .OSC_TICK(tick), .NV_RDATA(nv_rd), .REG_RDATA(rdata), .CPU_STALL(stall), .READY_IRQ(irq),
    .NV_WRITE_START(start), .NV_MODE(mode), .NV_ADDRESS(nva), .NV_WDATA(nvw));
  eac_core_model core_u (.clk, .rdata, .stall, .we, .re, .addr, .wdata);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) tick <= tick_en & ~tick;
  always @(negedge clk)
  begin
    cycles++;
    starts += int'(start === 1'b1);
    if (cycles > 3000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    compares++;
    if (g !== e) $display("mismatch %s expected %h seen %h", n, e, g);
    if (g !== e) miscompares++;
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    {nrst, gie, fsp, tick_en, nv_rd} = {4'b0, 8'h5A};
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    core_u.rd(2'h0, v);
    chk("control reset", 8'h00, v);
    foreach (rows[i])
    begin
      core_u.wr(rows[i].a, rows[i].d);
      core_u.rd(rows[i].a, v);
      chk("readback", rows[i].e, v);
    end
    gie = 1'b1;
    repeat (2) @(negedge clk);
    chk("ready irq", 1'b1, irq);
    gie = 1'b0;
    core_u.wr(2'h0, 8'h09);
    core_u.rd(2'h1, v);
    chk("read byte", 8'h5A, v);
    core_u.wr(2'h0, 8'h0C);
    core_u.rd(2'h0, v);
    chk("arm set", 1'b1, v[2]);
    repeat (4) @(negedge clk);
    core_u.rd(2'h0, v);
    chk("arm expired", 1'b0, v[2]);
    core_u.wr(2'h0, 8'h0A);
    fsp = 1'b1;
    core_u.nv_write(8'h08);
    fsp = 1'b0;
    @(negedge clk);
    chk("refused starts", 11'(0), 11'(starts));
    core_u.wr(2'h3, 8'h02);
    core_u.wr(2'h2, 8'h34);
    core_u.wr(2'h1, 8'hC3);
    core_u.nv_write(8'h28);
    @(negedge clk);
    chk("start", 11'(1), 11'(starts));
    chk("mode", 11'h2, mode);
    core_u.wr(2'h2, 8'h00);
    chk("address", 11'h234, nva);
    chk("wdata", 8'hC3, nvw);
    gie = 1'b1;
    repeat (2) @(negedge clk);
    chk("irq busy", 1'b0, irq);
    gie = 1'b0;
    core_u.wr(2'h0, 8'h18);
    nv_rd = 8'h77;
    core_u.wr(2'h0, 8'h09);
    core_u.rd(2'h1, v);
    chk("busy read", 8'hC3, v);
    chk("mode held", 11'h2, mode);
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    core_u.rd(2'h0, v);
    chk("busy control", 8'h22, v & 8'h33);
    tick_en = 1'b1;
    repeat (40) if (v[1]) core_u.rd(2'h0, v);
    chk("strobe cleared", 1'b0, v[1]);
    gie = 1'b1;
    core_u.wr(2'h0, 8'h08);
    repeat (2) @(negedge clk);
    chk("irq after write", 1'b1, irq);
    complete_run();
  end
endmodule
